// *** hdl/lpac_cfg.svh ***
// constants for the link partner ability capture block
// assumes inclusion by bare name from the package and the design files
`ifndef LPAC_CFG_SVH
`define LPAC_CFG_SVH
`define LPAC_ADDR_W 5
`define LPAC_OFF_ABILITY 5'h05
`define LPAC_OFF_CTRL 5'h10
`define LPAC_OFF_STATUS 5'h11
`define LPAC_WORD_RST 16'h0000
`define LPAC_BIT_NP 15
`define LPAC_BIT_ACK 14
`define LPAC_BIT_FAULT 13
`define LPAC_BIT_RSVD 12
`define LPAC_BIT_ASYM 11
`define LPAC_BIT_PAUSE 10
`define LPAC_BIT_T4 9
`define LPAC_BIT_TXFD 8
`define LPAC_BIT_TX 7
`define LPAC_BIT_TENFD 6
`define LPAC_BIT_TEN 5
`define LPAC_BIT_MP 13
`define LPAC_BIT_TOGGLE 11
`define LPAC_SEL_802_3 5'h01
`endif

// *** hdl/lpac_pkg.sv ***
// types for the link partner ability capture block
// assumes lpac_cfg.svh is on the include path
`include "lpac_cfg.svh"
package lpac_pkg;
    typedef enum logic [2:0]
    {
        LPAC_IDLE = 3'b001,
        LPAC_BASE = 3'b010,
        LPAC_NEXT = 3'b100
    } lpac_view_t;
endpackage : lpac_pkg

// *** hdl/lpac_page_if.sv ***
// carrier between the capture core and the top-level register block
// assumes one clock shared by both modules
`timescale 1ns/100ps
interface lpac_page_if;
    logic [15:0] shownWord;
    logic nextView;
    logic selIs8023;
    logic pageCount;
    modport core (output shownWord, output nextView, output selIs8023, output pageCount);
    modport top (input shownWord, input nextView, input selIs8023, input pageCount);
endinterface : lpac_page_if

// *** hdl/lpac_page_core.sv ***
// capture core: latches received link code words into base and next views
// assumes page strobes are one-cycle pulses synchronous to clock
`timescale 1ns/100ps
`include "lpac_cfg.svh"
module lpac_page_core
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [15:0] rxCodeWord,
    input wire logic pageReceived,
    input wire logic isNextPage,
    input wire logic anComplete,
    input wire logic nextPageEn,
    lpac_page_if.core pg
);
    logic [15:0] baseWord_q;
    logic [15:0] nextWord_q;
    logic haveNext_q;
    lpac_pkg::lpac_view_t view_q;
    lpac_pkg::lpac_view_t view_d;
    wire logic takeBase;
    wire logic takeNext;
    wire logic [15:0] cleanWord;

    // reserved base bit is forced low on capture; word accepted only on page strobe
    assign cleanWord = isNextPage ? rxCodeWord
                       : (rxCodeWord & ~(16'h0001 << `LPAC_BIT_RSVD));
    assign takeBase = pageReceived & ~isNextPage;
    assign takeNext = pageReceived & isNextPage & nextPageEn;

    // view choice: next page shown only after completion with next pages enabled
    always_comb
    begin
        case (view_q)
            lpac_pkg::LPAC_IDLE: view_d = takeBase ? lpac_pkg::LPAC_BASE : lpac_pkg::LPAC_IDLE;
            lpac_pkg::LPAC_BASE: view_d = (anComplete & nextPageEn & haveNext_q)
                                          ? lpac_pkg::LPAC_NEXT : lpac_pkg::LPAC_BASE;
            lpac_pkg::LPAC_NEXT: view_d = (takeBase | ~nextPageEn)
                                          ? lpac_pkg::LPAC_BASE : lpac_pkg::LPAC_NEXT;
            default: view_d = lpac_pkg::LPAC_IDLE;
        endcase
    end

    // page holding registers, hardware loaded only
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            baseWord_q <= `LPAC_WORD_RST;
            nextWord_q <= `LPAC_WORD_RST;
            haveNext_q <= 1'b0;
            view_q <= lpac_pkg::LPAC_IDLE;
        end
        else
        begin
            if (takeBase)
                baseWord_q <= cleanWord;
            if (takeNext)
                nextWord_q <= cleanWord;
            haveNext_q <= takeBase ? 1'b0 : (haveNext_q | takeNext);
            view_q <= view_d;
        end
    end

    assign pg.nextView = (view_q == lpac_pkg::LPAC_NEXT);
    assign pg.shownWord = pg.nextView ? nextWord_q : baseWord_q;
    assign pg.selIs8023 = (baseWord_q[4:0] == `LPAC_SEL_802_3);
    assign pg.pageCount = pageReceived;

    AST_BASE_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
        !pageReceived |=> $stable(baseWord_q))
        else $error("base word changed without a page");
    AST_RSVD_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
        !pg.nextView |-> pg.shownWord[`LPAC_BIT_RSVD] == 1'b0)
        else $error("reserved bit reads one");
    AST_NEXT_GATED: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(pg.nextView) |-> $past(anComplete) && $past(nextPageEn))
        else $error("next view without completion");
endmodule : lpac_page_core

// *** hdl/lpac_top.sv ***
// link partner ability capture: register view of received partner pages
// assumes a simple strobe register port with read data one cycle later
//
// Overview of operation
// - partner abilities readable at offset 0x05, read only
// - after completion with next pages enabled, show received next page
// - bit 15 shows partner next page request in both views
// - bit 14 shows partner acknowledge
// - acknowledge bit loaded by hardware from received bursts only
// - bit 13 shows partner remote fault
// - bit 12 reserved, reads zero in base view, software writes zero
// - bit 11 shows partner asymmetric pause
// - bit 10 shows partner symmetric pause
// - bit 9 shows partner four pair fast ability
// - bit 8 shows partner fast copper full duplex
// - bit 7 shows partner fast copper half duplex
// - bit 6 shows partner ten full duplex
// - bit 5 shows partner ten half duplex
// - bits 4:0 partner selector, all fields reset to zero
// - selector 00001 means 802.3 station
// - next view bits 10:0 carry code, message when bit 13 set
// - next view bit 11 reports partner toggle
`timescale 1ns/100ps
`include "lpac_cfg.svh"
module lpac_top
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    input wire logic [15:0] rxCodeWord,
    input wire logic pageReceived,
    input wire logic isNextPage,
    input wire logic anComplete,
    output logic partnerIs8023,
    output logic nextViewShown
);
    lpac_page_if pg();
    logic nextPageEn_q;
    logic [7:0] pageCnt_q;
    logic [15:0] rdData_q;
    logic is8023_q;
    logic nextShown_q;
    wire logic hitAbility;
    wire logic hitCtrl;
    wire logic hitStatus;
    wire logic [15:0] rdMux;
    wire logic [15:0] statusWord;

    lpac_page_core lpac_page_core_i
    (
        .clock(clock),
        .rst_b(rst_b),
        .rxCodeWord(rxCodeWord),
        .pageReceived(pageReceived),
        .isNextPage(isNextPage),
        .anComplete(anComplete),
        .nextPageEn(nextPageEn_q),
        .pg(pg)
    );

    // address decode
    assign hitAbility = (regAddr == `LPAC_OFF_ABILITY);
    assign hitCtrl = (regAddr == `LPAC_OFF_CTRL);
    assign hitStatus = (regAddr == `LPAC_OFF_STATUS);
    assign statusWord = {6'h00, pg.selIs8023, pg.nextView, pageCnt_q};

    // read selection; ability word passes whole, each bit is partner field except base reserved bit 12
    assign rdMux = hitAbility ? pg.shownWord
                 : hitCtrl ? {15'h0000, nextPageEn_q}
                 : hitStatus ? statusWord
                 : 16'h0000;

    // control write: ability word ignores writes (bit 14 included)
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            nextPageEn_q <= 1'b0;
        else if (regWrite && hitCtrl)
            nextPageEn_q <= regWrData[0];
    end

    // received page counter, wraps
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            pageCnt_q <= 8'h00;
        else if (pg.pageCount)
            pageCnt_q <= pageCnt_q + 8'h01;
    end

    // registered outputs
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdData_q <= 16'h0000;
            is8023_q <= 1'b0;
            nextShown_q <= 1'b0;
        end
        else
        begin
            rdData_q <= regRead ? rdMux : 16'h0000;
            is8023_q <= pg.selIs8023;
            nextShown_q <= pg.nextView;
        end
    end

    assign regRdData = rdData_q;
    assign partnerIs8023 = is8023_q;
    assign nextViewShown = nextShown_q;

    AST_READ_ABILITY: assert property (@(posedge clock) disable iff (!rst_b)
        (regRead && hitAbility) |=> regRdData == $past(pg.shownWord))
        else $error("ability read mismatch");
    AST_ACK_NOWRITE: assert property (@(posedge clock) disable iff (!rst_b)
        (regWrite && !pageReceived) |=> $stable(pg.shownWord) || $changed(pg.nextView))
        else $error("ability word changed by write");
    AST_RSVD_READ: assert property (@(posedge clock) disable iff (!rst_b)
        (regRead && hitAbility && !pg.nextView) |=> regRdData[`LPAC_BIT_RSVD] == 1'b0)
        else $error("reserved bit read as one");
    AST_BASE_LOAD: assert property (@(posedge clock) disable iff (!rst_b)
        (pageReceived && !isNextPage && !pg.nextView && !anComplete)
        |=> pg.shownWord[15:13] == $past(rxCodeWord[15:13]))
        else $error("top bits not captured");
    AST_FIELDS_LOAD: assert property (@(posedge clock) disable iff (!rst_b)
        (pageReceived && !isNextPage && !pg.nextView && !anComplete)
        |=> pg.shownWord[11:0] == $past(rxCodeWord[11:0]))
        else $error("ability fields not captured");
    AST_NEXT_FIELDS: assert property (@(posedge clock) disable iff (!rst_b)
        (pageReceived && isNextPage && nextPageEn_q && pg.nextView)
        |=> pg.shownWord == $past(rxCodeWord))
        else $error("next page not captured");
    AST_SEL_FLAG: assert property (@(posedge clock) disable iff (!rst_b)
        pg.selIs8023 |=> partnerIs8023)
        else $error("selector flag not reported");
    AST_NO_NEXT_OFF: assert property (@(posedge clock) disable iff (!rst_b)
        !nextPageEn_q |-> ##1 !pg.nextView)
        else $error("next view while disabled");
    AST_IDLE_READ: assert property (@(posedge clock) disable iff (!rst_b)
        !regRead |=> regRdData == 16'h0000)
        else $error("read data outside read slot");

    COV_BASE: cover property (@(posedge clock) disable iff (!rst_b)
        pageReceived && !isNextPage);
    COV_NEXT_VIEW: cover property (@(posedge clock) disable iff (!rst_b)
        $rose(pg.nextView));
    COV_READ_ABILITY: cover property (@(posedge clock) disable iff (!rst_b)
        regRead && hitAbility && pg.shownWord != 16'h0000);
endmodule : lpac_top

// *** test/lpac_partner.sv ***
// far-side model: negotiation logic handing received pages to the block
// assumes the bench calls send_page just after a rising clock edge
`timescale 1ns/100ps
module lpac_partner
(
    input wire logic clock,
    output logic [15:0] rxCodeWord,
    output logic pageReceived,
    output logic isNextPage
);
    // idle lines show the inverse of the last page, never a stale copy
    initial
    begin
        rxCodeWord = 16'h0000;
        pageReceived = 1'b0;
        isNextPage = 1'b0;
    end

    // one-cycle page strobe with the word and kind beside it
    task automatic send_page(input logic [15:0] w, input logic nxt);
        rxCodeWord <= w;
        isNextPage <= nxt;
        pageReceived <= 1'b1;
        @(posedge clock);
        pageReceived <= 1'b0;
        rxCodeWord <= ~w;
        isNextPage <= ~nxt;
        @(posedge clock);
    endtask : send_page
endmodule : lpac_partner

// *** test/lpac_top_bench.sv ***
// self-checking bench for the link partner ability capture block
// assumes lpac_partner stands in for the negotiation logic
`timescale 1ns/100ps
`include "lpac_cfg.svh"
module lpac_top_bench;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [15:0] regWrData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdData;
    logic [15:0] rxCodeWord;
    logic pageReceived;
    logic isNextPage;
    logic anComplete = 1'b0;
    logic partnerIs8023;
    logic nextViewShown;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    lpac_top lpac_top_i (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .rxCodeWord(rxCodeWord), .pageReceived(pageReceived),
        .isNextPage(isNextPage), .anComplete(anComplete),
        .partnerIs8023(partnerIs8023), .nextViewShown(nextViewShown));

    lpac_partner lpac_partner_i (.clock(clock), .rxCodeWord(rxCodeWord),
        .pageReceived(pageReceived), .isNextPage(isNextPage));

    // 4 ns clock
    initial
    begin
        forever #2 clock = ~clock;
    end

    // verdict and end of run
    task automatic complete_run;
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    // hang guard
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares = miscompares + 1;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one write cycle on the register port
    task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : reg_write

    // read, then sample the data in the single cycle it stands
    task automatic reg_read_check(input string what, input logic [4:0] a,
        input logic [15:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        check(what, exp, regRdData);
        @(posedge clock);
        #1;
        check("rdata idle", 16'h0000, regRdData);
    endtask : reg_read_check

    // reset values, unmapped read
    task automatic test_reset;
        reg_read_check("ability reset", `LPAC_OFF_ABILITY, `LPAC_WORD_RST);
        reg_read_check("unmapped", 5'h1f, 16'h0000);
        check("is8023 reset", 16'h0000, {15'h0000, partnerIs8023});
    endtask : test_reset

    // each single bit of a base page, reserved bit dropped
    task automatic test_base_bits;
        logic [15:0] w;
        for (int i = 0; i < 16; i++)
        begin
            w = 16'h0001 << i;
            lpac_partner_i.send_page(w, 1'b0);
            reg_read_check("base bit", `LPAC_OFF_ABILITY, (i == 12) ? 16'h0000 : w);
        end
        lpac_partner_i.send_page(16'hffff, 1'b0);
        reg_read_check("base all", `LPAC_OFF_ABILITY, 16'hefff);
    endtask : test_base_bits

    // a write to the status offset leaves the ability word unchanged, contents hold between strobes
    task automatic test_read_only;
        lpac_partner_i.send_page(16'h4c21, 1'b0);
        reg_write(`LPAC_OFF_STATUS, 16'hffff);
        reg_read_check("ro hold", `LPAC_OFF_ABILITY, 16'h4c21);
        check("is8023", 16'h0001, {15'h0000, partnerIs8023});
    endtask : test_read_only

    // next page refused when disabled, shown after completion when enabled
    task automatic test_next_page;
        lpac_partner_i.send_page(16'h3abc, 1'b1);
        anComplete <= 1'b1;
        repeat (3) @(posedge clock);
        reg_read_check("np refused", `LPAC_OFF_ABILITY, 16'h4c21);
        reg_write(`LPAC_OFF_CTRL, 16'h0001);
        lpac_partner_i.send_page(16'h3abc, 1'b1);
        repeat (3) @(posedge clock);
        reg_read_check("np view", `LPAC_OFF_ABILITY, 16'h3abc);
        check("np shown", 16'h0001, {15'h0000, nextViewShown});
        lpac_partner_i.send_page(16'hc7ff, 1'b1);
        repeat (3) @(posedge clock);
        reg_read_check("np toggle", `LPAC_OFF_ABILITY, 16'hc7ff);
        anComplete <= 1'b0;
        lpac_partner_i.send_page(16'h0021, 1'b0);
        repeat (3) @(posedge clock);
        reg_read_check("back to base", `LPAC_OFF_ABILITY, 16'h0021);
        check("np cleared", 16'h0000, {15'h0000, nextViewShown});
        reg_read_check("ctrl", `LPAC_OFF_CTRL, 16'h0001);
        reg_read_check("status", `LPAC_OFF_STATUS, 16'h0216);
    endtask : test_next_page

    // main sequence
    initial
    begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        test_reset();
        test_base_bits();
        test_read_only();
        test_next_page();
        complete_run();
    end
endmodule : lpac_top_bench
